// File: rafe_consts.svh
// Constants for the rectangular area fill engine: register map, fields, resets
`ifndef RAFE_CONSTS_SVH
`define RAFE_CONSTS_SVH

// Register word offsets on the byte address bus
`define RAFE_OFS_CTRL 8'h00
`define RAFE_OFS_DADDR 8'h04
`define RAFE_OFS_DYDX 8'h08
`define RAFE_OFS_COLOR 8'h0C
`define RAFE_OFS_DPTCH 8'h10
`define RAFE_OFS_OFFSET 8'h14
`define RAFE_OFS_DEST_PITCH_CONVERSION 8'h18
`define RAFE_OFS_STATUS 8'h1C

// Control register fields
`define RAFE_CTRL_START_BIT 0
`define RAFE_CTRL_LINEAR_BIT 1
`define RAFE_CTRL_PP_LSB 2
`define RAFE_CTRL_PP_MSB 5
`define RAFE_CTRL_PSZ_LSB 6
`define RAFE_CTRL_PSZ_MSB 8

// Status register fields
`define RAFE_STAT_BUSY_BIT 0
`define RAFE_STAT_ROW_LSB 16

// Reset values
`define RAFE_RST_CTRL 32'h0000_0080
`define RAFE_RST_DADDR 32'h0000_0000
`define RAFE_RST_DYDX 32'h0000_0000
`define RAFE_RST_COLOR 32'h0000_0000
`define RAFE_RST_DPTCH 32'h0000_1000
`define RAFE_RST_OFFSET 32'h0000_0000
`define RAFE_RST_DEST_PITCH_CONVERSION 32'h0000_0000

`endif

// File: rafe_fb_model.sv
// Frame buffer model answering word reads after a set latency and masked writes
`timescale 1ns/1ps
module rafe_fb_model (
    input wire logic core_clk_i,
    input wire logic [26:0] mem_addr_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic [31:0] mem_wmask_i,
    input wire logic [3:0] lat_i,
    output logic [31:0] mem_rdata_o,
    output logic mem_rvalid_o
);
    logic [31:0] mem [256];
    logic [7:0] ra;
    int cnt;
    // Seed the array with a pattern so untouched words are easy to tell apart
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i * 32'h9E37_79B1;
        cnt = 0;
        mem_rvalid_o = 1'b0;
        mem_rdata_o = 32'h0;
    end
    // Data lines toggle every idle cycle so a stale word can never look valid
    always @(posedge core_clk_i) begin
        mem_rvalid_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (mem_rd_i) begin
            ra = mem_addr_i[7:0];
            cnt = lat_i;
        end
        if (cnt == 1) begin
            mem_rvalid_o <= 1'b1;
            mem_rdata_o <= mem[ra];
        end
        if (cnt > 0) cnt--;
        if (mem_wr_i) mem[mem_addr_i[7:0]] = (mem[mem_addr_i[7:0]] & ~mem_wmask_i) | (mem_wdata_i & mem_wmask_i);
    end
endmodule : rafe_fb_model

// File: rafe_fill_engine.sv
// Rectangular area fill engine: register port, fill sequencer and frame buffer master
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "rafe_consts.svh"
module rafe_fill_engine (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic busy_o,
    output logic [26:0] mem_addr_o,
    output logic mem_rd_o,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_rvalid_i,
    output logic mem_wr_o,
    output logic [31:0] mem_wdata_o,
    output logic [31:0] mem_wmask_o
);
    import rafe_pkg::*;

    rafe_state_e state_r, state_nxt;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] daddr_r, daddr_nxt;
    logic [31:0] dydx_r, dydx_nxt;
    logic [31:0] colour_r, colour_nxt;
    logic [31:0] dptch_r, dptch_nxt;
    logic [31:0] offset_r, offset_nxt;
    logic [31:0] dest_pitch_conversion_r, dest_pitch_conversion_nxt;
    logic [31:0] row_addr_r, row_addr_nxt;
    logic [31:0] pix_addr_r, pix_addr_nxt;
    logic [15:0] x_cnt_r, x_cnt_nxt;
    logic [15:0] y_cnt_r, y_cnt_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [26:0] mem_addr_r, mem_addr_nxt;
    logic mem_rd_r, mem_rd_nxt;
    logic mem_wr_r, mem_wr_nxt;
    logic [31:0] mem_wdata_r, mem_wdata_nxt;
    logic [31:0] mem_wmask_r, mem_wmask_nxt;

    logic [31:0] op_result;
    logic [15:0] width;
    logic [15:0] height;
    logic [15:0] start_x;
    logic [15:0] start_y;
    rafe_pp_t pp_sel;
    rafe_psz_t psz_log;
    logic [5:0] pix_bits;
    logic [32:0] mask_wide;
    logic [31:0] pix_mask;
    logic [31:0] xy_start;
    logic [31:0] start_addr;
    logic [31:0] y_term;
    logic start_req;
    logic busy;
    logic [31:0] mode_word;
    rafe_psz_t start_psz;

    // Field extraction from the operand registers
    assign height = dydx_r[31:16];
    assign width = dydx_r[15:0];
    assign start_y = daddr_r[31:16];
    assign start_x = daddr_r[15:0];
    assign pp_sel = ctrl_r[`RAFE_CTRL_PP_MSB:`RAFE_CTRL_PP_LSB];
    assign psz_log = ctrl_r[`RAFE_CTRL_PSZ_MSB:`RAFE_CTRL_PSZ_LSB];
    assign busy = (state_r != RAFE_S_IDLE);
    assign start_req = reg_wr_i && (reg_addr_i == `RAFE_OFS_CTRL) && reg_wdata_i[`RAFE_CTRL_START_BIT];

    // The starting write carries the new mode; the control register only holds it one cycle later
    assign mode_word = start_req ? reg_wdata_i : ctrl_r;
    assign start_psz = mode_word[`RAFE_CTRL_PSZ_MSB:`RAFE_CTRL_PSZ_LSB];

    // Pixel size in bits, capped at a full word
    assign pix_bits = (psz_log > 3'd5) ? 6'd32 : 6'(6'd1 << psz_log);

    // Mask of the current pixel within its word; other pixels stay untouched
    assign mask_wide = (33'h0_0000_0001 << pix_bits) - 33'h0_0000_0001;
    assign pix_mask = mask_wide[31:0] << pix_addr_r[4:0];

    // Coordinate start: offset plus Y rows of pitch plus X pixels
    assign y_term = 32'(dptch_r * {16'h0000, start_y});
    assign xy_start = offset_r + y_term + 32'({16'h0000, start_x} << start_psz);
    assign start_addr = mode_word[`RAFE_CTRL_LINEAR_BIT] ? daddr_r : xy_start;

    // Colour pattern aligned to the word, so each pixel sees its own colour bits
    rafe_pixel_op u_pixel_op (
        .op_i(pp_sel),
        .src_i(colour_r),
        .dst_i(mem_rdata_i),
        .res_o(op_result)
    );

    // Register file, read port and fill sequencer next-state logic
    always_comb begin
        state_nxt = state_r;
        ctrl_nxt = ctrl_r;
        daddr_nxt = daddr_r;
        dydx_nxt = dydx_r;
        colour_nxt = colour_r;
        dptch_nxt = dptch_r;
        offset_nxt = offset_r;
        dest_pitch_conversion_nxt = dest_pitch_conversion_r;
        row_addr_nxt = row_addr_r;
        pix_addr_nxt = pix_addr_r;
        x_cnt_nxt = x_cnt_r;
        y_cnt_nxt = y_cnt_r;
        rdata_nxt = 32'h0000_0000;
        mem_addr_nxt = mem_addr_r;
        mem_rd_nxt = 1'b0;
        mem_wr_nxt = 1'b0;
        mem_wdata_nxt = mem_wdata_r;
        mem_wmask_nxt = mem_wmask_r;

        // Writes are ignored while a fill runs, so the operands cannot shift under it
        if (reg_wr_i && !busy) begin
            case (reg_addr_i)
                `RAFE_OFS_CTRL: ctrl_nxt = {23'h00_0000, reg_wdata_i[8:1], 1'b0};
                `RAFE_OFS_DADDR: daddr_nxt = reg_wdata_i;
                `RAFE_OFS_DYDX: dydx_nxt = reg_wdata_i;
                `RAFE_OFS_COLOR: colour_nxt = reg_wdata_i;
                `RAFE_OFS_DPTCH: dptch_nxt = reg_wdata_i;
                `RAFE_OFS_OFFSET: offset_nxt = reg_wdata_i;
                `RAFE_OFS_DEST_PITCH_CONVERSION: dest_pitch_conversion_nxt = reg_wdata_i;
                default: ;
            endcase
        end

        // Read data stand one cycle after the strobe; unmapped reads return zero
        if (reg_rd_i) begin
            case (reg_addr_i)
                `RAFE_OFS_CTRL: rdata_nxt = ctrl_r;
                `RAFE_OFS_DADDR: rdata_nxt = daddr_r;
                `RAFE_OFS_DYDX: rdata_nxt = dydx_r;
                `RAFE_OFS_COLOR: rdata_nxt = colour_r;
                `RAFE_OFS_DPTCH: rdata_nxt = dptch_r;
                `RAFE_OFS_OFFSET: rdata_nxt = offset_r;
                `RAFE_OFS_DEST_PITCH_CONVERSION: rdata_nxt = dest_pitch_conversion_r;
                `RAFE_OFS_STATUS: rdata_nxt = {y_cnt_r, 15'h0000, busy};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end

        case (state_r)
            RAFE_S_IDLE: begin
                // An empty rectangle touches no memory at all
                if (start_req && (width != 16'h0000) && (height != 16'h0000)) begin
                    row_addr_nxt = start_addr;
                    pix_addr_nxt = start_addr;
                    x_cnt_nxt = 16'h0000;
                    y_cnt_nxt = 16'h0000;
                    state_nxt = RAFE_S_READ;
                end
            end
            RAFE_S_READ: begin
                mem_addr_nxt = pix_addr_r[31:5];
                mem_rd_nxt = 1'b1;
                state_nxt = RAFE_S_WAIT;
            end
            RAFE_S_WAIT: begin
                // Read-modify-write keeps neighbouring pixels in the same word intact
                if (mem_rvalid_i) begin
                    mem_wdata_nxt = op_result;
                    mem_wmask_nxt = pix_mask;
                    mem_wr_nxt = 1'b1;
                    state_nxt = RAFE_S_STEP;
                end
            end
            RAFE_S_STEP: begin
                if (x_cnt_r == 16'(width - 16'h0001)) begin
                    x_cnt_nxt = 16'h0000;
                    y_cnt_nxt = 16'(y_cnt_r + 16'h0001);
                    row_addr_nxt = row_addr_r + dptch_r;
                    pix_addr_nxt = row_addr_r + dptch_r;
                    if (y_cnt_r == 16'(height - 16'h0001)) begin
                        // Start register left at the next row start, not preserved
                        daddr_nxt = row_addr_r + dptch_r;
                        state_nxt = RAFE_S_IDLE;
                    end else begin
                        state_nxt = RAFE_S_READ;
                    end
                end else begin
                    x_cnt_nxt = 16'(x_cnt_r + 16'h0001);
                    pix_addr_nxt = pix_addr_r + {26'h000_0000, pix_bits};
                    state_nxt = RAFE_S_READ;
                end
            end
            default: state_nxt = RAFE_S_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= RAFE_S_IDLE;
            ctrl_r <= `RAFE_RST_CTRL;
            daddr_r <= `RAFE_RST_DADDR;
            dydx_r <= `RAFE_RST_DYDX;
            colour_r <= `RAFE_RST_COLOR;
            dptch_r <= `RAFE_RST_DPTCH;
            offset_r <= `RAFE_RST_OFFSET;
            dest_pitch_conversion_r <= `RAFE_RST_DEST_PITCH_CONVERSION;
            row_addr_r <= 32'h0000_0000;
            pix_addr_r <= 32'h0000_0000;
            x_cnt_r <= 16'h0000;
            y_cnt_r <= 16'h0000;
            rdata_r <= 32'h0000_0000;
            mem_addr_r <= 27'h000_0000;
            mem_rd_r <= 1'b0;
            mem_wr_r <= 1'b0;
            mem_wdata_r <= 32'h0000_0000;
            mem_wmask_r <= 32'h0000_0000;
            busy_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            daddr_r <= daddr_nxt;
            dydx_r <= dydx_nxt;
            colour_r <= colour_nxt;
            dptch_r <= dptch_nxt;
            offset_r <= offset_nxt;
            dest_pitch_conversion_r <= dest_pitch_conversion_nxt;
            row_addr_r <= row_addr_nxt;
            pix_addr_r <= pix_addr_nxt;
            x_cnt_r <= x_cnt_nxt;
            y_cnt_r <= y_cnt_nxt;
            rdata_r <= rdata_nxt;
            mem_addr_r <= mem_addr_nxt;
            mem_rd_r <= mem_rd_nxt;
            mem_wr_r <= mem_wr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            mem_wmask_r <= mem_wmask_nxt;
            busy_o <= (state_nxt != RAFE_S_IDLE);
        end
    end

    // Outputs come straight from flip-flops
    assign reg_rdata_o = rdata_r;
    assign mem_addr_o = mem_addr_r;
    assign mem_rd_o = mem_rd_r;
    assign mem_wr_o = mem_wr_r;
    assign mem_wdata_o = mem_wdata_r;
    assign mem_wmask_o = mem_wmask_r;
endmodule : rafe_fill_engine

// File: rafe_fill_engine_sva.sv
// Checker for the fill engine's read port and frame buffer handshake
`timescale 1ns/1ps
module rafe_fill_engine_sva (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic busy_o,
    input wire logic [26:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_rvalid_i,
    input wire logic mem_wr_o,
    input wire logic [31:0] mem_wmask_o
);
    logic pend_r;
    logic pend_nxt;
    // Outstanding read; a stray valid outside it must be ignored
    always_comb begin
        pend_nxt = pend_r;
        if (mem_rd_o) pend_nxt = 1'b1;
        else if (mem_rvalid_i) pend_nxt = 1'b0;
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) pend_r <= 1'b0;
        else pend_r <= pend_nxt;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("stale rdata");
    chk_access_busy: assert property (mem_rd_o || mem_wr_o |-> busy_o) else $error("access while idle");
    chk_no_overlap: assert property (!(mem_rd_o && mem_wr_o)) else $error("read and write together");
    chk_wr_cause: assert property (mem_wr_o |-> $past(mem_rvalid_i) && $past(pend_r)) else $error("write uncaused");
    chk_valid_to_wr: assert property (mem_rvalid_i && pend_r |=> mem_wr_o) else $error("write missing");
    chk_addr_hold: assert property (mem_wr_o |-> $stable(mem_addr_o)) else $error("write addr moved");
    chk_mask_set: assert property (mem_wr_o |-> mem_wmask_o != 32'h0) else $error("empty mask");
    chk_one_out: assert property (pend_r |-> !mem_rd_o) else $error("second read");
    cover property (mem_wr_o);
    cover property (reg_rd_i ##1 reg_rdata_o != 32'h0);
    cover property ($fell(busy_o));
endmodule : rafe_fill_engine_sva

bind rafe_fill_engine rafe_fill_engine_sva u_sva (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .busy_o(busy_o), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_rvalid_i(mem_rvalid_i), .mem_wr_o(mem_wr_o), .mem_wmask_o(mem_wmask_o));

// File: rafe_fill_engine_tb_top.sv
// Self-checking bench: register port plus fills against a frame buffer model
`timescale 1ns/1ps
`include "rafe_consts.svh"
module rafe_fill_engine_tb_top;
    logic core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, busy_o, mem_rd_o, mem_wr_o, mem_rvalid_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, mem_rdata_i, mem_wdata_o, mem_wmask_o;
    logic [26:0] mem_addr_o;
    logic [3:0] lat;
    logic [31:0] exp_m [256];
    int mismatches = 0;
    int n_compared = 0;
    rafe_fill_engine u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .busy_o(busy_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i),
        .mem_rvalid_i(mem_rvalid_i), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_wmask_o(mem_wmask_o));
    rafe_fb_model u_fb (.core_clk_i(core_clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
        .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_wmask_i(mem_wmask_o), .lat_i(lat),
        .mem_rdata_o(mem_rdata_i), .mem_rvalid_o(mem_rvalid_i));
    // 125 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    task automatic complete_run;
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    // Strobes rise after one edge and drop after the next, so calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        cmp(reg_rdata_o, e);
    endtask : rd
    task automatic wait_busy(input logic v);
        for (int i = 0; i < 3000 && busy_o !== v; i++) @(negedge core_clk_i);
        if (busy_o !== v) begin
            mismatches++;
            complete_run();
        end
    endtask : wait_busy
    function automatic logic [3:0] pop(input logic [3:0] o, input logic [3:0] s, input logic [3:0] d);
        case (o)
            4'h1: pop = s & d;
            4'hA: pop = s ^ d;
            4'h6: pop = ~d;
            default: pop = s;
        endcase
    endfunction : pop
    // One 3 x 5 fill of 4-bit pixels; a colour write while busy must be dropped
    task automatic fill(input logic lin, input logic [3:0] op, input logic [31:0] da, input logic [31:0] col,
                        input logic [3:0] l);
        logic [31:0] base, a;
        logic [4:0] b;
        base = lin ? da : 32'h40 + da[31:16] * 32'h100 + (da[15:0] << 2);
        lat = l;
        wr(`RAFE_OFS_DADDR, da);
        wr(`RAFE_OFS_DYDX, 32'h0003_0005);
        wr(`RAFE_OFS_COLOR, col);
        for (int i = 0; i < 256; i++) exp_m[i] = u_fb.mem[i];
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 5; c++) begin
                a = base + r * 32'h100 + c * 4;
                b = a[4:0];
                exp_m[a[12:5]][b +: 4] = pop(op, col[b +: 4], exp_m[a[12:5]][b +: 4]);
            end
        end
        wr(`RAFE_OFS_CTRL, {23'h0, 3'h2, op, lin, 1'b1});
        wait_busy(1'b1);
        wr(`RAFE_OFS_COLOR, ~col);
        wait_busy(1'b0);
        for (int i = 0; i < 256; i++) cmp(u_fb.mem[i], exp_m[i]);
        rd(`RAFE_OFS_COLOR, col);
        rd(`RAFE_OFS_DADDR, base + 32'h300);
    endtask : fill
    // Reset, register defaults, then fills in both addressing modes
    initial begin
        reset_n_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        lat = 4'h1;
        repeat (6) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        rd(`RAFE_OFS_CTRL, `RAFE_RST_CTRL);
        rd(`RAFE_OFS_DPTCH, `RAFE_RST_DPTCH);
        rd(`RAFE_OFS_STATUS, 32'h0);
        rd(8'h20, 32'h0);
        wr(`RAFE_OFS_DPTCH, 32'h0000_0100);
        wr(`RAFE_OFS_OFFSET, 32'h0000_0040);
        wr(`RAFE_OFS_DEST_PITCH_CONVERSION, 32'h0000_0017);
        rd(`RAFE_OFS_DEST_PITCH_CONVERSION, 32'h0000_0017);
        fill(1'b0, 4'h0, 32'h0002_0003, 32'h0000_2255, 4'h1);
        fill(1'b1, 4'hA, 32'h0000_0F1C, 32'h89AB_CDEF, 4'h5);
        fill(1'b0, 4'h1, 32'h0004_0006, 32'h2222_2222, 4'h3);
        fill(1'b1, 4'h6, 32'h0000_0A00, 32'h0000_0000, 4'h2);
        complete_run();
    end
endmodule : rafe_fill_engine_tb_top

// File: rafe_pixel_op.sv
// Pixel processing operation applied between source pattern and destination word
`timescale 1ns/1ps
module rafe_pixel_op (
    input wire rafe_pkg::rafe_pp_t op_i,
    input wire logic [31:0] src_i,
    input wire logic [31:0] dst_i,
    output logic [31:0] res_o
);
    import rafe_pkg::*;

    // Boolean operations work on whole words; the write mask keeps other pixels
    always_comb begin
        case (op_i)
            4'h0: res_o = src_i;
            4'h1: res_o = src_i & dst_i;
            4'h2: res_o = src_i & ~dst_i;
            4'h3: res_o = 32'h0000_0000;
            4'h4: res_o = src_i | ~dst_i;
            4'h5: res_o = ~(src_i ^ dst_i);
            4'h6: res_o = ~dst_i;
            4'h7: res_o = ~(src_i | dst_i);
            4'h8: res_o = src_i | dst_i;
            4'h9: res_o = dst_i;
            4'hA: res_o = src_i ^ dst_i;
            4'hB: res_o = ~src_i & dst_i;
            4'hC: res_o = 32'hFFFF_FFFF;
            4'hD: res_o = ~src_i | dst_i;
            4'hE: res_o = ~(src_i & dst_i);
            default: res_o = ~src_i;
        endcase
    end
endmodule : rafe_pixel_op

// File: rafe_pkg.sv
// Types shared by the rectangular area fill engine
package rafe_pkg;
    typedef enum logic [1:0] {
        RAFE_S_IDLE,
        RAFE_S_READ,
        RAFE_S_WAIT,
        RAFE_S_STEP
    } rafe_state_e;

    typedef logic [3:0] rafe_pp_t;
    typedef logic [2:0] rafe_psz_t;
endpackage : rafe_pkg
